// ---- rtl/tlih_defines.svh ----
// Register offsets, field positions and reset values of the interrupt handler
`ifndef TLIH_DEFINES_SVH
`define TLIH_DEFINES_SVH

`define TLIH_OFF_HIGH_FLAGS   4'h0
`define TLIH_OFF_MID_FLAGS    4'h1
`define TLIH_OFF_LOW_FLAGS    4'h2
`define TLIH_OFF_HIGH_EN      4'h3
`define TLIH_OFF_MID_EN       4'h4
`define TLIH_OFF_LOW_EN       4'h5
`define TLIH_OFF_CODE         4'h6
`define TLIH_OFF_SUMMARY      4'h7

`define TLIH_WORD_LSB         2
`define TLIH_WORD_MSB         5

`define TLIH_FLAGS_RESET      8'h00
`define TLIH_EN_RESET         8'h00
`define TLIH_CODE_NONE        8'hff
`define TLIH_SUMMARY_RESET    8'h00

`define TLIH_SUM_HIGH_BIT     2
`define TLIH_SUM_MID_BIT      1
`define TLIH_SUM_LOW_BIT      0

`define TLIH_GROUP_BASE_HIGH  5'h10
`define TLIH_GROUP_BASE_MID   5'h08
`define TLIH_GROUP_BASE_LOW   5'h00
`define TLIH_GROUP_SIZE       8
`define TLIH_GROUP_ALL        8'hff

`define TLIH_RESP_OKAY        2'b00
`define TLIH_RESP_SLVERR      2'b10

`endif

// ---- rtl/tlih_pkg.sv ----
// Types shared by the interrupt handler
package tlih_pkg;

  typedef logic [7:0]  tlih_group_t;
  typedef logic [23:0] tlih_sources_t;

  typedef enum logic [1:0] {
    TLIH_GRP_HIGH,
    TLIH_GRP_MID,
    TLIH_GRP_LOW
  } tlih_group_e;

endpackage : tlih_pkg

// ---- rtl/tlih_irq_handler.sv ----
// Three-level interrupt handler with AXI4-Lite register access
//
// Functional notes
// - Twenty-four sources handled individually, in three groups of eight.
// - High, mid, low groups drive core levels first, second, third.
// - High flags hold sources 23..16 in bits 7..0, reset zero.
// - Mid flags hold sources 15..8 in bits 7..0, reset zero.
// - Low flags hold sources 7..0 in bits 7..0, reset zero.
// - Writing one to a flag bit clears that pending flag.
// - Enable registers read/write, one bit per source, one enables, reset zero.
// - Priority code register read-only, eight bits, resets to all ones.
// - Summary bit 2 set while any high flag pending.
// - Summary bit 1 set while any mid flag pending.
// - Summary bit 0 for low group; bits 7..3 read zero.
// - Flag sets only on enabled source's rising edge.
// - Writing zero to a flag bit leaves it unchanged.
// - Priority code reads all ones when nothing pending.
// - Sources sampled on system clock; core line rises three cycles after edge.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.

`include "tlih_defines.svh"

module tlih_irq_handler (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire tlih_pkg::tlih_sources_t irq_sources,
  output logic                       core_level_first,
  output logic                       core_level_second,
  output logic                       core_level_third,
  input  wire logic [5:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [5:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // ==========================================================================
  // Source synchronisation and edge detection
  // ==========================================================================
  tlih_pkg::tlih_sources_t src_meta;
  tlih_pkg::tlih_sources_t src_sync;
  tlih_pkg::tlih_sources_t src_prev;
  tlih_pkg::tlih_sources_t src_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta <= '0;
      src_sync <= '0;
      src_prev <= '0;
    end else begin
      src_meta <= irq_sources;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  assign src_rise = src_sync & ~src_prev;

  // ==========================================================================
  // Register state
  // ==========================================================================
  tlih_pkg::tlih_sources_t flags;
  tlih_pkg::tlih_sources_t enables;
  tlih_pkg::tlih_sources_t clear_mask;
  logic [7:0]              priority_code;
  logic [7:0]              next_priority_code;
  logic [7:0]              group_summary;

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  logic [5:0]  wr_addr;
  logic        wr_addr_held;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_data_held;
  logic        wr_fire;
  logic [3:0]  wr_word;

  assign wr_fire = wr_addr_held && wr_data_held && !s_axi_bvalid;
  assign wr_word = wr_addr[`TLIH_WORD_MSB:`TLIH_WORD_LSB];

  function automatic logic tlih_mapped(input logic [3:0] word);
    tlih_mapped = (word <= `TLIH_OFF_SUMMARY);
  endfunction : tlih_mapped

  function automatic logic tlih_writable(input logic [3:0] word);
    tlih_writable = (word <= `TLIH_OFF_LOW_EN);
  endfunction : tlih_writable

  // Group addressed by a flag or enable word
  function automatic tlih_pkg::tlih_group_e tlih_group_of(input logic [3:0] word);
    case (word)
      `TLIH_OFF_HIGH_FLAGS,
      `TLIH_OFF_HIGH_EN:    tlih_group_of = tlih_pkg::TLIH_GRP_HIGH;
      `TLIH_OFF_MID_FLAGS,
      `TLIH_OFF_MID_EN:     tlih_group_of = tlih_pkg::TLIH_GRP_MID;
      default:              tlih_group_of = tlih_pkg::TLIH_GRP_LOW;
    endcase
  endfunction : tlih_group_of

  // One group of eight out of a source vector
  function automatic tlih_pkg::tlih_group_t tlih_group_pick(
    input tlih_pkg::tlih_sources_t vec,
    input tlih_pkg::tlih_group_e   grp
  );
    case (grp)
      tlih_pkg::TLIH_GRP_HIGH: tlih_group_pick = vec[`TLIH_GROUP_BASE_HIGH +: `TLIH_GROUP_SIZE];
      tlih_pkg::TLIH_GRP_MID:  tlih_group_pick = vec[`TLIH_GROUP_BASE_MID +: `TLIH_GROUP_SIZE];
      default:                 tlih_group_pick = vec[`TLIH_GROUP_BASE_LOW +: `TLIH_GROUP_SIZE];
    endcase
  endfunction : tlih_group_pick

  // A group of eight put back at its sources, all others zero
  function automatic tlih_pkg::tlih_sources_t tlih_group_place(
    input tlih_pkg::tlih_group_t grp_bits,
    input tlih_pkg::tlih_group_e grp
  );
    tlih_pkg::tlih_sources_t placed;
    placed = '0;
    case (grp)
      tlih_pkg::TLIH_GRP_HIGH: placed[`TLIH_GROUP_BASE_HIGH +: `TLIH_GROUP_SIZE] = grp_bits;
      tlih_pkg::TLIH_GRP_MID:  placed[`TLIH_GROUP_BASE_MID +: `TLIH_GROUP_SIZE]  = grp_bits;
      default:                 placed[`TLIH_GROUP_BASE_LOW +: `TLIH_GROUP_SIZE]  = grp_bits;
    endcase
    tlih_group_place = placed;
  endfunction : tlih_group_place

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr_held  <= 1'b0;
      wr_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !wr_addr_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_held  <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        wr_addr_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_data_held <= 1'b0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wr_data_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_held <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        wr_data_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TLIH_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= tlih_mapped(wr_word) ? `TLIH_RESP_OKAY : `TLIH_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Enables and flags
  // ==========================================================================
  logic                  wr_lane0;
  logic                  wr_to_flags;
  logic                  wr_to_enables;
  tlih_pkg::tlih_group_e wr_group;

  // Read-only and unmapped words never reach the state below
  assign wr_lane0      = wr_fire && wr_strb[0] && tlih_writable(wr_word);
  assign wr_to_flags   = wr_lane0 && (wr_word < `TLIH_OFF_HIGH_EN);
  assign wr_to_enables = wr_lane0 && (wr_word >= `TLIH_OFF_HIGH_EN);
  assign wr_group      = tlih_group_of(wr_word);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables <= {3{`TLIH_EN_RESET}};
    end else if (wr_to_enables) begin
      // Only the addressed group changes
      enables <= (enables & ~tlih_group_place(`TLIH_GROUP_ALL, wr_group)) |
                 tlih_group_place(wr_data[`TLIH_GROUP_SIZE-1:0], wr_group);
    end
  end

  // Ones clear, zeros keep
  always_comb begin
    clear_mask = '0;
    if (wr_to_flags) begin
      clear_mask = tlih_group_place(wr_data[`TLIH_GROUP_SIZE-1:0], wr_group);
    end
  end

  // ==========================================================================
  // Next flag value: an enabled new edge wins over a clear
  // ==========================================================================
  tlih_pkg::tlih_sources_t next_flags;

  assign next_flags = (flags & ~clear_mask) | (src_rise & enables);

  genvar g;
  generate
    for (g = 0; g < 24; g++) begin : g_flag
      // New edge wins over a clear in the same cycle
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags[g] <= 1'b0;
        end else if (src_rise[g] && enables[g]) begin
          flags[g] <= 1'b1;
        end else if (clear_mask[g]) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Core request lines, summary and priority code
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_level_first  <= 1'b0;
      core_level_second <= 1'b0;
      core_level_third  <= 1'b0;
    end else begin
      // Built from next flag value so the line follows the edge by one cycle
      core_level_first  <= |tlih_group_pick(next_flags, tlih_pkg::TLIH_GRP_HIGH);
      core_level_second <= |tlih_group_pick(next_flags, tlih_pkg::TLIH_GRP_MID);
      core_level_third  <= |tlih_group_pick(next_flags, tlih_pkg::TLIH_GRP_LOW);
    end
  end

  always_comb begin
    group_summary = `TLIH_SUMMARY_RESET;
    group_summary[`TLIH_SUM_HIGH_BIT] = |flags[23:16];
    group_summary[`TLIH_SUM_MID_BIT]  = |flags[15:8];
    group_summary[`TLIH_SUM_LOW_BIT]  = |flags[7:0];
  end

  always_comb begin
    next_priority_code = `TLIH_CODE_NONE;
    for (int i = 0; i < 24; i++) begin
      if (flags[i]) begin
        next_priority_code = 8'(i);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priority_code <= `TLIH_CODE_NONE;
    end else begin
      priority_code <= next_priority_code;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  logic [3:0] rd_word;
  logic [7:0] rd_value;

  assign rd_word = s_axi_araddr[`TLIH_WORD_MSB:`TLIH_WORD_LSB];

  always_comb begin
    rd_value = 8'h00;
    case (rd_word)
      `TLIH_OFF_HIGH_FLAGS,
      `TLIH_OFF_MID_FLAGS,
      `TLIH_OFF_LOW_FLAGS:  rd_value = tlih_group_pick(flags, tlih_group_of(rd_word));
      `TLIH_OFF_HIGH_EN,
      `TLIH_OFF_MID_EN,
      `TLIH_OFF_LOW_EN:     rd_value = tlih_group_pick(enables, tlih_group_of(rd_word));
      `TLIH_OFF_CODE:       rd_value = priority_code;
      `TLIH_OFF_SUMMARY:    rd_value = group_summary;
      default:              rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `TLIH_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_value};
        s_axi_rresp   <= tlih_mapped(rd_word) ? `TLIH_RESP_OKAY : `TLIH_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : tlih_irq_handler

// ---- sim/tlih_checker.sv ----
// Port-level assertions of the interrupt handler
module tlih_checker (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire tlih_pkg::tlih_sources_t irq_sources,
  input wire logic                    core_level_first,
  input wire logic                    core_level_second,
  input wire logic                    core_level_third,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic [5:0]              s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====================================================
  // Assertions
  a_lines_reset: assert property ($rose(aresetn) |->
    !core_level_first && !core_level_second && !core_level_third) else $error("line after reset");
  a_first_cause: assert property ($rose(core_level_first) |->
    ($past(irq_sources[23:16], 3) | $past(irq_sources[23:16], 4)) != 8'h00) else $error("high rise");
  a_third_cause: assert property ($rose(core_level_third) |->
    ($past(irq_sources[7:0], 3) | $past(irq_sources[7:0], 4)) != 8'h00) else $error("low rise");
  a_fall_on_clear: assert property ($fell(core_level_second) |->
    $past(s_axi_bvalid) || s_axi_bvalid) else $error("mid line fell without clear");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid ##1 !s_axi_rvalid) else $error("read response timing");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h20
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  a_data_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_summary_upper: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h1c
    |=> s_axi_rdata[7:3] == 5'h00) else $error("summary unused bits set");
  c_high_rise: cover property ($rose(core_level_first));
  c_mid_fall: cover property ($fell(core_level_second));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : tlih_checker

// ---- sim/tlih_peer.sv ----
// Peripheral source stand-in driving the handler inputs
module tlih_peer (
  input  wire logic                    aclk,
  input  wire logic [23:0]             fire,
  input  wire logic [3:0]              width,
  output tlih_pkg::tlih_sources_t      irq_sources
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  initial irq_sources = 24'h00_0000;
  // Pulse of chosen length on each fired source
  always @(posedge aclk) begin
    if (fire != 24'h00_0000) begin
      irq_sources <= fire;
      cnt <= width;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      irq_sources <= 24'h00_0000;
    end
  end
endmodule : tlih_peer

// ---- sim/tb_three_level_irq_handler.sv ----
// Self-checking bench of the three-level interrupt handler
module tb_three_level_irq_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf, width = 4'h2;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd, r32;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_level_first, core_level_second, core_level_third;
  logic [23:0] fire = 24'h00_0000, m_flags = 24'h00_0000, m_en = 24'h00_0000;
  tlih_pkg::tlih_sources_t irq_sources;
  int n_errors = 0;
  int total_checks = 0;
  always #12.5 aclk = ~aclk;
  tlih_irq_handler tlih_irq_handler_i (.aclk, .aresetn, .irq_sources, .core_level_first,
    .core_level_second, .core_level_third, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tlih_peer tlih_peer_i (.aclk, .fire, .width, .irq_sources);
  // ====================================================
  // Tasks
  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0; rs = s_axi_bresp;
    if (i == 40) begin chk("write wait", 32'h0000_0000, 32'h0000_0001); stop_test(); end
  endtask : wr
  task rd_reg(input logic [5:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0; rd = s_axi_rdata; rs = s_axi_rresp;
    if (i == 40) begin chk("read wait", 32'h0000_0000, 32'h0000_0001); stop_test(); end
  endtask : rd_reg
  function logic [31:0] exp_reg(input int w);
    exp_reg = 32'h0000_00ff;
    case (w)
      0, 1, 2: exp_reg = {24'h00_0000, m_flags[8*(2-w) +: 8]};
      3, 4, 5: exp_reg = {24'h00_0000, m_en[8*(5-w) +: 8]};
      6: for (int k = 0; k < 24; k++) if (m_flags[k]) exp_reg = k;
      default: exp_reg = {29'h0, m_flags[23:16] != 0, m_flags[15:8] != 0, m_flags[7:0] != 0};
    endcase
  endfunction : exp_reg
  task chk_all;
    for (int w = 0; w < 8; w++) begin
      rd_reg({w[3:0], 2'b00});
      chk("register", exp_reg(w), rd);
    end
    chk("core lines", {29'h0, |m_flags[23:16], |m_flags[15:8], |m_flags[7:0]},
        {29'h0, core_level_first, core_level_second, core_level_third});
  endtask : chk_all
  // ====================================================
  // Main sequence
  initial begin
    void'($urandom(33));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    rd_reg(6'h20);
    chk("unmapped read", 32'h0000_0000, rd);
    chk("unmapped read resp", 32'h0000_0002, {30'h0, rs});
    wr(6'h20, 32'hffff_ffff);
    chk("unmapped write", 32'h0000_0002, {30'h0, rs});
    wr(6'h18, 32'h0000_0000);
    chk("read-only write", 32'h0000_0000, {30'h0, rs});
    for (int t = 0; t < 8; t++) begin
      r32 = $urandom;
      m_en = r32[23:0];
      for (int w = 0; w < 3; w++) wr({w[3:0], 2'b00} + 6'h0c, {24'h00_0000, m_en[8*(2-w) +: 8]});
      r32 = $urandom;
      fire <= r32[23:0];
      width <= r32[27:24] | 4'h2;
      @(posedge aclk);
      fire <= 24'h00_0000;
      m_flags = m_flags | (r32[23:0] & m_en);
      repeat (20) @(posedge aclk);
      chk_all();
      r32 = $urandom;
      for (int w = 0; w < 3; w++) wr({w[3:0], 2'b00}, {24'h00_0000, r32[8*(2-w) +: 8]});
      m_flags = m_flags & ~r32[23:0];
      chk_all();
    end
    s_axi_wstrb <= 4'he;
    wr(6'h0c, 32'h0000_00ff);
    s_axi_wstrb <= 4'hf;
    chk("masked write", 32'h0000_0000, {30'h0, rs});
    for (int w = 0; w < 3; w++) wr({w[3:0], 2'b00}, 32'h0000_00ff);
    m_flags = 24'h00_0000;
    chk_all();
    m_en = 24'hff_ffff;
    for (int w = 0; w < 3; w++) wr({w[3:0], 2'b00} + 6'h0c, 32'h0000_00ff);
    fire <= 24'hff_ffff;
    @(posedge aclk);
    fire <= 24'h00_0000;
    m_flags = 24'hff_ffff;
    repeat (20) @(posedge aclk);
    chk_all();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    m_flags = 24'h00_0000;
    m_en = 24'h00_0000;
    chk_all();
    stop_test();
  end
endmodule : tb_three_level_irq_handler

bind tlih_irq_handler tlih_checker tlih_checker_i (.aclk, .aresetn, .irq_sources,
  .core_level_first, .core_level_second, .core_level_third, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
